// file: verilog/cstsel_top.sv
// Clock start-up timing select: fuse copy, trim, reset and wake delays
module cstsel_top
#(
  parameter logic [14:0] MS65_WDT_CK  = 15'h2000,
  parameter logic [14:0] WAKE_16K_CK  = 15'h4000
)
(
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  // Fuses and factory trim
  input  wire cstsel_pkg::cstsel_fuse_s  fuse_in,
  // Oscillator levels and wake request
  input  wire logic                      src_osc_in,
  input  wire logic                      wdt_osc_in,
  input  wire logic                      wake_req_in,
  // APB slave
  input  wire cstsel_pkg::cstsel_apb_req_s apb_in,
  output logic                           pready_out,
  output logic                           pslverr_out,
  output logic [31:0]                    prdata_out,
  // Clock control outputs
  output logic                           core_clk_en_out,
  output logic [7:0]                     rc_trim_out,
  output logic                           rc_div8_out,
  output logic                           xtal_sel_out,
  output logic [2:0]                     xtal_mode_out,
  output logic                           wdt_tick_out,
  output logic                           cfg_err_out
);

  // Module state apart from the reset synchronizer and edge detectors
  typedef struct packed {
    cstsel_pkg::cstsel_state_e st;
    logic [14:0]               cnt;
    logic [14:0]               wake;
    cstsel_pkg::cstsel_ms_e    ms;
    logic [3:0]                src;
    logic [1:0]                startup_delay_fuses;
    logic [7:0]                trim;
    logic [31:0]               rdata;
    logic                      clk_en;
    logic                      err;
  } cstsel_state_s;

  cstsel_state_s r_r;
  cstsel_state_s r_nxt;
  logic          rst_meta_r;
  logic          rst_n;
  logic          src_tick;
  logic          wdt_tick;
  logic          setup;
  logic          access;
  logic          mapped;
  cstsel_pkg::cstsel_timing_s tim;

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Edge detectors for both oscillators
  cstsel_edge u_src_edge (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .level_in (src_osc_in),
    .rise_out (src_tick)
  );

  cstsel_edge u_wdt_edge (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .level_in (wdt_osc_in),
    .rise_out (wdt_tick)
  );

  // Decode start-up timing from source and start-up fields
  function automatic cstsel_pkg::cstsel_timing_s decode(
    input logic [3:0] src,
    input logic [1:0] startup_delay_fuses,
    input logic       rst_dis
  );
    cstsel_pkg::cstsel_timing_s t;
    t.wake = cstsel_pkg::WAKE_INT_CK;
    t.ms   = cstsel_pkg::MS_NONE;
    t.err  = 1'b0;
    if (src[3])
    begin
      case ({src[0], startup_delay_fuses})
        3'h0: begin t.wake = cstsel_pkg::WAKE_258_CK; t.ms = cstsel_pkg::MS_4P1; end
        3'h1: begin t.wake = cstsel_pkg::WAKE_258_CK; t.ms = cstsel_pkg::MS_65; end
        3'h2: begin t.wake = cstsel_pkg::WAKE_1K_CK; t.ms = cstsel_pkg::MS_NONE; end
        3'h3: begin t.wake = cstsel_pkg::WAKE_1K_CK; t.ms = cstsel_pkg::MS_4P1; end
        3'h4: begin t.wake = cstsel_pkg::WAKE_1K_CK; t.ms = cstsel_pkg::MS_65; end
        3'h5: begin t.wake = WAKE_16K_CK; t.ms = cstsel_pkg::MS_NONE; end
        3'h6: begin t.wake = WAKE_16K_CK; t.ms = cstsel_pkg::MS_4P1; end
        default: begin t.wake = WAKE_16K_CK; t.ms = cstsel_pkg::MS_65; end
      endcase
    end
    else
    begin
      // Internal sources: 6 cycles on wake for every code
      t.wake = cstsel_pkg::WAKE_INT_CK;
      case (startup_delay_fuses)
        2'h0: t.ms = cstsel_pkg::MS_NONE;
        2'h1: t.ms = cstsel_pkg::MS_4P1;
        2'h2: t.ms = cstsel_pkg::MS_65;
        default:
        begin
          t.ms  = cstsel_pkg::MS_65;
          t.err = 1'b1;
        end
      endcase
      if (src != cstsel_pkg::SRC_RC8M && src != cstsel_pkg::SRC_OSC128K)
        t.err = 1'b1;
    end
    // No-delay options withdrawn while the reset pin is disabled
    if (rst_dis && t.ms == cstsel_pkg::MS_NONE)
      t.ms = cstsel_pkg::MS_4P1;
    return t;
  endfunction

  // Bus phase decode
  assign setup  = apb_in.psel & ~apb_in.penable;
  assign access = apb_in.psel & apb_in.penable;
  assign mapped = (apb_in.paddr == cstsel_pkg::ADDR_CLKSEL) ||
                  (apb_in.paddr == cstsel_pkg::ADDR_TRIM) ||
                  (apb_in.paddr == cstsel_pkg::ADDR_STATUS);
  assign tim    = decode(r_r.src, r_r.startup_delay_fuses, fuse_in.rst_pin_dis);

  // Next state: sequencer and register file
  always_comb
  begin
    r_nxt = r_r;
    case (r_r.st)
      cstsel_pkg::S_LOAD:
      begin
        r_nxt.src  = fuse_in.src;
        r_nxt.startup_delay_fuses  = fuse_in.startup_delay_fuses;
        r_nxt.trim = fuse_in.trim;
        r_nxt.cnt  = '0;
        r_nxt.st   = cstsel_pkg::S_RST_CK;
      end
      cstsel_pkg::S_RST_CK:
      begin
        if (src_tick)
        begin
          r_nxt.cnt = r_r.cnt + 15'h0001;
          if (r_r.cnt == cstsel_pkg::RST_CK - 15'h0001)
          begin
            r_nxt.cnt = '0;
            r_nxt.ms  = tim.ms;
            r_nxt.err = tim.err;
            if (tim.ms == cstsel_pkg::MS_NONE)
            begin
              r_nxt.st     = cstsel_pkg::S_RUN;
              r_nxt.clk_en = 1'b1;
            end
            else
              r_nxt.st = cstsel_pkg::S_RST_MS;
          end
        end
      end
      cstsel_pkg::S_RST_MS:
      begin
        // Real-time part timed by the watchdog oscillator
        if (wdt_tick)
        begin
          r_nxt.cnt = r_r.cnt + 15'h0001;
          if ((r_r.ms == cstsel_pkg::MS_4P1 &&
               r_r.cnt == cstsel_pkg::MS4_WDT_CK - 15'h0001) ||
              (r_r.ms == cstsel_pkg::MS_65 &&
               r_r.cnt == MS65_WDT_CK - 15'h0001))
          begin
            r_nxt.cnt    = '0;
            r_nxt.st     = cstsel_pkg::S_RUN;
            r_nxt.clk_en = 1'b1;
          end
        end
      end
      cstsel_pkg::S_RUN:
      begin
        if (wake_req_in)
        begin
          r_nxt.st     = cstsel_pkg::S_WAKE;
          r_nxt.clk_en = 1'b0;
          r_nxt.cnt    = '0;
          r_nxt.wake   = tim.wake;
          r_nxt.err    = tim.err;
        end
      end
      cstsel_pkg::S_WAKE:
      begin
        // Counted on edges of the selected source only
        if (src_tick)
        begin
          r_nxt.cnt = r_r.cnt + 15'h0001;
          if (r_r.cnt == r_r.wake - 15'h0001)
          begin
            r_nxt.cnt    = '0;
            r_nxt.st     = cstsel_pkg::S_RUN;
            r_nxt.clk_en = 1'b1;
          end
        end
      end
      default:
      begin
        r_nxt.st     = cstsel_pkg::S_LOAD;
        r_nxt.clk_en = 1'b0;
      end
    endcase

    // Register writes take effect in the access phase
    if (access && apb_in.pwrite && r_r.st != cstsel_pkg::S_LOAD)
    begin
      if (apb_in.paddr == cstsel_pkg::ADDR_CLKSEL)
      begin
        r_nxt.src = apb_in.pwdata[cstsel_pkg::CS_SRC_LSB +: 4];
        r_nxt.startup_delay_fuses = apb_in.pwdata[cstsel_pkg::CS_SUT_LSB +: 2];
      end
      if (apb_in.paddr == cstsel_pkg::ADDR_TRIM)
        r_nxt.trim = apb_in.pwdata[7:0];
    end

    // Read data captured in the setup phase
    if (setup)
    begin
      r_nxt.rdata = '0;
      case (apb_in.paddr)
        cstsel_pkg::ADDR_CLKSEL:
        begin
          r_nxt.rdata[cstsel_pkg::CS_SRC_LSB +: 4] = r_r.src;
          r_nxt.rdata[cstsel_pkg::CS_SUT_LSB +: 2] = r_r.startup_delay_fuses;
        end
        cstsel_pkg::ADDR_TRIM:
          r_nxt.rdata[7:0] = r_r.trim;
        cstsel_pkg::ADDR_STATUS:
        begin
          r_nxt.rdata[cstsel_pkg::ST_CLKEN_BIT]  = r_r.clk_en;
          r_nxt.rdata[cstsel_pkg::ST_RSTDLY_BIT] =
            (r_r.st == cstsel_pkg::S_RST_CK) ||
            (r_r.st == cstsel_pkg::S_RST_MS);
          r_nxt.rdata[cstsel_pkg::ST_WAKE_BIT]   =
            (r_r.st == cstsel_pkg::S_WAKE);
          r_nxt.rdata[cstsel_pkg::ST_ERR_BIT]    = r_r.err;
          r_nxt.rdata[cstsel_pkg::ST_XTAL_BIT]   = r_r.src[3];
          r_nxt.rdata[cstsel_pkg::ST_MODE_LSB +: 3] = r_r.src[3:1];
          r_nxt.rdata[cstsel_pkg::ST_DIV8_BIT]   = rc_div8_out;
        end
        default: r_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_r        <= '0;
      r_r.st     <= cstsel_pkg::S_LOAD;
      r_r.ms     <= cstsel_pkg::MS_NONE;
      r_r.src    <= cstsel_pkg::SRC_RESET;
      r_r.startup_delay_fuses    <= cstsel_pkg::SUT_RESET;
      r_r.trim   <= cstsel_pkg::TRIM_RESET;
    end
    else
      r_r <= r_nxt;
  end

  // Outputs
  assign pready_out      = 1'b1;
  assign pslverr_out     = access & ~mapped;
  assign prdata_out      = r_r.rdata;
  assign core_clk_en_out = r_r.clk_en;
  assign rc_trim_out     = r_r.trim;
  assign rc_div8_out     = fuse_in.div8 & (r_r.src == cstsel_pkg::SRC_RC8M);
  assign xtal_sel_out    = r_r.src[3];
  assign xtal_mode_out   = r_r.src[3:1];
  assign wdt_tick_out    = wdt_tick;
  assign cfg_err_out     = r_r.err;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  // Checks
  sequence s_load;
    r_r.st == cstsel_pkg::S_LOAD;
  endsequence
  sequence s_rst_ck_end;
    r_r.st == cstsel_pkg::S_RST_CK && src_tick &&
    r_r.cnt == cstsel_pkg::RST_CK - 15'h0001;
  endsequence

  property p_trim_load;
    s_load |=> rc_trim_out == $past(fuse_in.trim);
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("factory trim not loaded");

  property p_trim_write;
    access && apb_in.pwrite && apb_in.paddr == cstsel_pkg::ADDR_TRIM &&
    r_r.st != cstsel_pkg::S_LOAD |=> rc_trim_out == $past(apb_in.pwdata[7:0]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("trim write lost");

  property p_fuse_copy;
    s_load |=> r_r.src == $past(fuse_in.src) && r_r.startup_delay_fuses == $past(fuse_in.startup_delay_fuses);
  endproperty
  a_fuse_copy: assert property (p_fuse_copy)
    else $error("fuses not copied");

  property p_wdt_fwd;
    $rose(wdt_osc_in) |-> wdt_tick_out;
  endproperty
  a_wdt_fwd: assert property (p_wdt_fwd)
    else $error("watchdog tick missing");

  property p_int_nodelay;
    s_rst_ck_end and (r_r.src[3] == 1'b0 && r_r.startup_delay_fuses == 2'h0 &&
    !fuse_in.rst_pin_dis) |=> r_r.st == cstsel_pkg::S_RUN && core_clk_en_out;
  endproperty
  a_int_nodelay: assert property (p_int_nodelay)
    else $error("14 cycle reset delay wrong");

  property p_rstdis;
    s_rst_ck_end and fuse_in.rst_pin_dis |=> r_r.st == cstsel_pkg::S_RST_MS;
  endproperty
  a_rstdis: assert property (p_rstdis)
    else $error("no-delay option used with reset pin disabled");

  property p_ms4_end;
    r_r.st == cstsel_pkg::S_RST_MS && r_r.ms == cstsel_pkg::MS_4P1 &&
    wdt_tick && r_r.cnt == cstsel_pkg::MS4_WDT_CK - 15'h0001
    |=> core_clk_en_out;
  endproperty
  a_ms4_end: assert property (p_ms4_end)
    else $error("4.1 ms time-out count wrong");

  property p_wake_gate;
    r_r.st == cstsel_pkg::S_RUN && wake_req_in && !r_r.src[3]
    |=> !core_clk_en_out [*8];
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake delay too short");

  property p_xtal_258;
    r_r.st == cstsel_pkg::S_RUN && wake_req_in && r_r.src[3] &&
    {r_r.src[0], r_r.startup_delay_fuses} == 3'h0 |=> r_r.wake == cstsel_pkg::WAKE_258_CK;
  endproperty
  a_xtal_258: assert property (p_xtal_258)
    else $error("crystal wake count wrong");

  property p_wake_count;
    r_r.st == cstsel_pkg::S_WAKE && !src_tick |=> $stable(r_r.cnt);
  endproperty
  a_wake_count: assert property (p_wake_count)
    else $error("wake counted without source edge");

endmodule // cstsel_top

// file: verilog/cstsel_pkg.sv
// Package: constants and types for the clock start-up timing select block
package cstsel_pkg;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CLKSEL   = 8'h00;
  localparam logic [7:0]  ADDR_TRIM     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;

  // Clock select register field positions
  localparam int          CS_SRC_LSB    = 0;
  localparam int          CS_SUT_LSB    = 4;

  // Status register field positions
  localparam int          ST_CLKEN_BIT  = 0;
  localparam int          ST_RSTDLY_BIT = 1;
  localparam int          ST_WAKE_BIT   = 2;
  localparam int          ST_ERR_BIT    = 3;
  localparam int          ST_XTAL_BIT   = 4;
  localparam int          ST_MODE_LSB   = 5;
  localparam int          ST_DIV8_BIT   = 8;

  // Reset values before fuses are copied in (shipped defaults)
  localparam logic [3:0]  SRC_RESET     = 4'h2;
  localparam logic [1:0]  SUT_RESET     = 2'h2;
  localparam logic [7:0]  TRIM_RESET    = 8'h00;

  // Source select codes
  localparam logic [3:0]  SRC_RC8M      = 4'h2;
  localparam logic [3:0]  SRC_OSC128K   = 4'h3;

  // Crystal operating modes on source select bits 3..1
  localparam logic [2:0]  XMODE_0P4_0P9 = 3'h4;
  localparam logic [2:0]  XMODE_0P9_3P0 = 3'h5;
  localparam logic [2:0]  XMODE_3P0_8P0 = 3'h6;
  localparam logic [2:0]  XMODE_8P0_16P = 3'h7;

  // Start-up counts in cycles of the selected source
  localparam logic [14:0] WAKE_INT_CK   = 15'h0006;
  localparam logic [14:0] WAKE_258_CK   = 15'h0102;
  localparam logic [14:0] WAKE_1K_CK    = 15'h0400;
  localparam logic [14:0] RST_CK        = 15'h000e;

  // Reset time-out in watchdog oscillator cycles (4.1 ms)
  localparam logic [14:0] MS4_WDT_CK    = 15'h0200;

  // Millisecond part of the reset delay
  typedef enum logic [1:0] {
    MS_NONE,
    MS_4P1,
    MS_65
  } cstsel_ms_e;

  // Decoded start-up timing
  typedef struct packed {
    logic [14:0] wake;
    cstsel_ms_e  ms;
    logic        err;
  } cstsel_timing_s;

  // Sequencer states
  typedef enum logic [2:0] {
    S_LOAD,
    S_RST_CK,
    S_RST_MS,
    S_RUN,
    S_WAKE
  } cstsel_state_e;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cstsel_apb_req_s;

  // Fuse and factory values
  typedef struct packed {
    logic [3:0]  src;
    logic [1:0]  startup_delay_fuses;
    logic        rst_pin_dis;
    logic        div8;
    logic [7:0]  trim;
  } cstsel_fuse_s;

endpackage : cstsel_pkg

// file: verilog/cstsel_edge.sv
// Rising edge detector for an oscillator level sampled on the system clock
module cstsel_edge
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Oscillator level and its edge
  input  wire logic level_in,
  output logic      rise_out
);

  logic prev_r;

  // Previous sample of the level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prev_r <= 1'b0;
    else
      prev_r <= level_in;
  end

  // One-cycle pulse on each rising edge
  assign rise_out = level_in & ~prev_r;

endmodule // cstsel_edge

// file: tb/cstsel_osc_model.sv
// Model of the source and watchdog oscillators seen by the block
module cstsel_osc_model
(
  // System clock
  input  wire logic clk_in,
  // Oscillator levels
  output logic      src_osc_out,
  output logic      wdt_osc_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cyc_r = 4'h0;
  logic       src_r = 1'h0;
  logic       wdt_r = 1'h0;

  // Source rises every 4 clocks, watchdog every 12, never on one edge
  always @(posedge clk_in)
  begin
    cyc_r <= (cyc_r == 4'hb) ? 4'h0 : cyc_r + 4'h1;
    src_r <= cyc_r[1];
    wdt_r <= (cyc_r < 4'h6);
  end

  // Levels to the block
  assign src_osc_out = src_r;
  assign wdt_osc_out = wdt_r;
endmodule // cstsel_osc_model

// file: tb/tb_clock_startup_timing_select.sv
// Testbench for the clock start-up timing select block
module tb_clock_startup_timing_select;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0]  src;
    logic [1:0]  startup_delay_fuses;
    logic        rdis;
    logic        div8;
    logic [7:0]  trim;
    logic [15:0] wake;
    logic [15:0] ms;
    logic        err;
  } cstsel_row_s;

  // Fuse settings with the delays they should give (wake 0: not tried)
  cstsel_row_s rows [15] = '{
    '{4'h2, 2'h0, 1'h0, 1'h1, 8'h5a, 16'h0006, 16'h0000, 1'h0},
    '{4'h0, 2'h0, 1'h0, 1'h0, 8'h3e, 16'h0006, 16'h0000, 1'h1},
    '{4'h2, 2'h1, 1'h0, 1'h0, 8'h11, 16'h0006, 16'h0200, 1'h0},
    '{4'h2, 2'h2, 1'h0, 1'h1, 8'h80, 16'h0006, 16'h0010, 1'h0},
    '{4'h2, 2'h3, 1'h0, 1'h0, 8'hc3, 16'h0000, 16'h0010, 1'h1},
    '{4'h3, 2'h0, 1'h1, 1'h0, 8'h01, 16'h0006, 16'h0200, 1'h0},
    '{4'h3, 2'h2, 1'h0, 1'h0, 8'hfe, 16'h0006, 16'h0010, 1'h0},
    '{4'h8, 2'h0, 1'h0, 1'h0, 8'h22, 16'h0102, 16'h0200, 1'h0},
    '{4'h8, 2'h2, 1'h0, 1'h0, 8'h33, 16'h0400, 16'h0000, 1'h0},
    '{4'h9, 2'h0, 1'h0, 1'h0, 8'h44, 16'h0400, 16'h0010, 1'h0},
    '{4'h9, 2'h1, 1'h1, 1'h0, 8'h55, 16'h0014, 16'h0200, 1'h0},
    '{4'hd, 2'h2, 1'h0, 1'h0, 8'h66, 16'h0014, 16'h0200, 1'h0},
    '{4'hf, 2'h3, 1'h0, 1'h0, 8'h77, 16'h0014, 16'h0010, 1'h0},
    '{4'hc, 2'h3, 1'h0, 1'h0, 8'h99, 16'h0400, 16'h0200, 1'h0},
    '{4'hb, 2'h1, 1'h0, 1'h0, 8'h88, 16'h0014, 16'h0000, 1'h0}};

  logic                        clk_in      = 1'h0;
  logic                        nrst_in     = 1'h0;
  logic                        wake_req_in = 1'h0;
  cstsel_pkg::cstsel_fuse_s    fuse_in     = '0;
  cstsel_pkg::cstsel_apb_req_s apb_in      = '0;
  logic                        src_osc;
  logic                        wdt_osc;
  logic                        pready_out;
  logic                        pslverr_out;
  logic [31:0]                 prdata_out;
  logic                        core_clk_en_out;
  logic [7:0]                  rc_trim_out;
  logic                        rc_div8_out;
  logic                        xtal_sel_out;
  logic [2:0]                  xtal_mode_out;
  logic                        wdt_tick_out;
  logic                        cfg_err_out;
  int                          err_count    = 0;
  int                          total_checks = 0;
  int                          ns;
  int                          nw;
  logic                        c0;
  logic                        se;
  logic [31:0]                 rd;
  cstsel_row_s                 r;

  // Design with shortened long counts
  cstsel_top #(.MS65_WDT_CK(15'h0010), .WAKE_16K_CK(15'h0014)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .fuse_in(fuse_in),
    .src_osc_in(src_osc), .wdt_osc_in(wdt_osc), .wake_req_in(wake_req_in),
    .apb_in(apb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .core_clk_en_out(core_clk_en_out),
    .rc_trim_out(rc_trim_out), .rc_div8_out(rc_div8_out),
    .xtal_sel_out(xtal_sel_out), .xtal_mode_out(xtal_mode_out),
    .wdt_tick_out(wdt_tick_out), .cfg_err_out(cfg_err_out));

  // Oscillators
  cstsel_osc_model osc (.clk_in(clk_in), .src_osc_out(src_osc),
                        .wdt_osc_out(wdt_osc));

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rdat,
                     output logic serr);
    @(posedge clk_in);
    apb_in <= '{1'h1, 1'h0, wr, a, d};
    @(posedge clk_in);
    apb_in.penable <= 1'h1;
    @(posedge clk_in);
    // Only the hang guard ends a slave that never answers
    while (pready_out !== 1'h1)
      @(posedge clk_in);
    rdat = prdata_out;
    serr = pslverr_out;
    apb_in <= '0;
  endtask

  // Count oscillator rises until the core clock is ungated
  task automatic measure(output int cs, output int cw, output logic first);
    logic ps;
    logic pw;
    int   i;
    cs = 0;
    cw = 0;
    ps = src_osc;
    pw = wdt_osc;
    for (i = 0; i < 20000; i++)
    begin
      @(posedge clk_in);
      wake_req_in <= 1'h0;
      if (src_osc && !ps)
        cs++;
      if (wdt_osc && !pw && cs >= 14)
        cw++;
      ps = src_osc;
      pw = wdt_osc;
      #1;
      if (i == 0)
        first = core_clk_en_out;
      if (core_clk_en_out === 1'h1)
        break;
    end
  endtask

  // Start a wake-up just after a source rise and time it
  task automatic wake;
    @(posedge src_osc);
    @(posedge clk_in);
    wake_req_in <= 1'h1;
    measure(ns, nw, c0);
    check("gated on wake", c0, 32'h0);
  endtask

  // Hang guard
  initial
  begin
    #500000;
    err_count++;
    stop_test;
  end

  // Main sequence: one reset per row and a wake-up for each row with a nonzero wake, then special cases
  initial
  begin
    foreach (rows[k])
    begin
      r = rows[k];
      @(posedge clk_in);
      nrst_in <= 1'h0;
      fuse_in <= '{r.src, r.startup_delay_fuses, r.rdis, r.div8, r.trim};
      repeat (5) @(posedge clk_in);
      @(posedge src_osc);
      @(posedge clk_in);
      nrst_in <= 1'h1;
      measure(ns, nw, c0);
      if (r.ms == 16'h0000)
        check("reset source cycles", ns, 32'd14);
      else
        check("reset wdt cycles", nw, {16'h0, r.ms});
      check("config error", cfg_err_out, {31'h0, r.err});
      check("trim loaded", rc_trim_out, {24'h0, r.trim});
      check("div8", rc_div8_out, {31'h0, r.div8 && r.src == 4'h2});
      check("mode", {xtal_sel_out, xtal_mode_out}, {r.src[3], r.src[3:1]});
      apb(1'h0, 8'h00, 32'h0, rd, se);
      check("select copy", rd, {26'h0, r.startup_delay_fuses, r.src});
      if (r.wake != 16'h0000)
      begin
        wake;
        check("wake cycles", ns, {16'h0, r.wake});
      end
    end
    apb(1'h1, 8'h04, 32'hffffff3c, rd, se);
    apb(1'h0, 8'h04, 32'h0, rd, se);
    check("trim readback", rd, 32'h3c);
    check("trim out", rc_trim_out, 32'h3c);
    apb(1'h1, 8'h00, 32'h19, rd, se);
    wake;
    check("wake from register", ns, 32'd20);
    apb(1'h0, 8'h0c, 32'h0, rd, se);
    check("unmapped error", se, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'h1, 8'h08, 32'h0, rd, se);
    apb(1'h0, 8'h08, 32'h0, rd, se);
    check("status running", rd[0], 32'h1);
    @(posedge src_osc);
    @(posedge clk_in);
    wake_req_in <= 1'h1;
    repeat (10) @(posedge clk_in);
    wake_req_in <= 1'h0;
    check("gated while waking", core_clk_en_out, 32'h0);
    // Reset must land while the core clock runs
    wait (core_clk_en_out === 1'h1);
    @(posedge clk_in);
    nrst_in     <= 1'h0;
    #1;
    check("gated in reset", core_clk_en_out, 32'h0);
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    check("trim reloaded", rc_trim_out, {24'h0, r.trim});
    // Watchdog tick stands for one clock after each rise
    @(posedge wdt_osc);
    #1;
    check("watchdog tick", wdt_tick_out, 32'h1);
    @(posedge clk_in);
    #1;
    check("watchdog tick end", wdt_tick_out, 32'h0);
    stop_test;
  end
endmodule // tb_clock_startup_timing_select
